// ---- rtl/cfg_port_regs.vh ----
`ifndef CFG_PORT_REGS_VH
`define CFG_PORT_REGS_VH

// ----------------------------------------------------------------
// Configuration array geometry
// ----------------------------------------------------------------
`define ROWS 16
`define ROW_W 32
`define ROW_ZERO 32'h0000_0000
`define ADDR_ZERO 16'h0000
`define ID_W 8
`define ID_ZERO 8'h00

// ----------------------------------------------------------------
// Serial commands, latched from the command shifter
// ----------------------------------------------------------------
`define CMD_W 3
`define CMD_NOP 3'h0
`define CMD_ADDR_SHIFT 3'h1
`define CMD_DATA_SHIFT 3'h2
`define CMD_PROGRAM 3'h3
`define CMD_VERIFY 3'h4
`define CMD_READ_ID 3'h5
`define CMD_ERASE 3'h6

// ----------------------------------------------------------------
// Pin synchroniser bit positions
// ----------------------------------------------------------------
`define SYNC_W 6
`define SY_ENABLE_N 0
`define SY_SDI 1
`define SY_MODE 2
`define SY_SDO_PIN 3
`define SY_SCLK 4
`define SY_GOE 5
`define SYNC_IDLE 6'h01 // Enable pin idles high, others low

// ----------------------------------------------------------------
// Fields of the stored configuration that steer the array side
// ----------------------------------------------------------------
`define ROW_LB_ROUTE 0
`define ROW_IO_ROUTE 1
`define ROW_GOE_CFG 2
`define GOE_MODE_BIT 0
`define LB_COUNT 16
`define IO_COUNT 32

// ----------------------------------------------------------------
// Cell write timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define PROG_PULSE_NS 200
`define PROG_PULSE_CYC ((`PROG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 8
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01

`endif

// ---- rtl/two_entry_buf.v ----
`timescale 1ns/10ps
`default_nettype none

module two_entry_buf #(
  parameter WIDTH = 49
) (
  input wire clk, // System clock
  input wire rst, // Async reset, active high
  input wire in_valid, // Producer offers a word
  output wire in_ready, // Buffer has room
  input wire [WIDTH-1:0] in_data, // Word offered
  output wire out_valid, // Oldest word present
  input wire out_ready, // Consumer takes the word
  output wire [WIDTH-1:0] out_data // Oldest word
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] slot_q [0:1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] count_q;
  wire push_w;
  wire pop_w;

  // Handshakes; full stalls the producer
  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = slot_q[rd_ptr_q];
  assign push_w = in_valid && in_ready;
  assign pop_w = out_valid && out_ready;

  // Data slots, no reset needed
  always @(posedge clk) begin
    if (push_w) begin
      slot_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointer and occupancy update
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push_w) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop_w) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push_w && !pop_w) begin
        count_q <= count_q + 2'h1;
      end else if (pop_w && !push_w) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- rtl/serial_cfg_port.v ----
// Functional notes
// RQ1: The programming link is five logic-level pins: enable, data in, data out, shift clock and mode.
// RQ2: An on-chip state machine sequences all programming, driven only by those serial pins.
// RQ3: Pulling the enable low enters programming mode and turns on the mode, data and clock functions.
// RQ4: With the enable high, data-in, data-out and mode pins are only plain dedicated array inputs.
// RQ5: In programming mode, data in is shifted into the device on the shift clock.
// RQ6: Data in together with mode steer the state machine, both driven by the programmer.
// RQ7: In programming mode the mode pin directs the state machine.
// RQ8: In programming mode the device drives data out with the shift register contents; the code drives a ready flag in the command state and zero in idle.
// RQ9: In programming mode the shift clock clocks the shift register, supplied by the programmer.
// RQ10: With the enable high the shift clock pin is a dedicated clock into the clock network.
// RQ11: That clock can be routed by option to any logic block and any I/O cell.
// RQ12: A one in a row's address bit enables that row for programming or verify; a zero excludes it.
// RQ13: A read-ID command yields an eight-bit identifier for the programmer to shift out.
// RQ14: Programmed cells keep their pattern through power loss with no reload.
// RQ15: The global-enable pin acts by configuration as global output enable or as a logic input.
// RQ16: The programmer holds the enable low for the whole sequence and releases it afterwards.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_port_regs.vh"

module serial_cfg_port #(
  parameter [7:0] DEVICE_ID = 8'h5a // Arbitrary identifier value
) (
  input wire clk, // System clock
  input wire rst, // Async reset, active high
  input wire prog_enable_n, // Programming enable pin, low active
  input wire serial_prog_in, // Serial data in pin
  input wire mode_in, // Mode control pin
  input wire serial_prog_out_i, // Data out pin, input side
  output reg serial_prog_out_o, // Data out pin, driven value
  output reg serial_prog_out_oe, // Data out pin, drive enable
  input wire clock_input_two, // Shift clock pin
  input wire goe_in, // Global enable / input pin
  output reg [2:0] array_in_q, // Dedicated inputs to the array
  output reg clock_net_q, // Clock into distribution network
  output reg [`LB_COUNT-1:0] lb_clock_q, // Clock per logic block
  output reg [`IO_COUNT-1:0] io_clock_q, // Clock per I/O cell
  output reg global_oe_q, // Global output enable
  output reg goe_array_in_q, // Global pin as logic input
  output reg prog_mode_q // Programming mode active
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_SHIFT_CMD = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;
  localparam BUF_W = 1 + `ROWS + `ROW_W;
  localparam [31:0] PULSE_CYC = `PROG_PULSE_CYC;

  reg [`SYNC_W-1:0] sync1_q;
  reg [`SYNC_W-1:0] sync2_q;
  reg sclk_prev_q;
  reg [1:0] state_q;
  reg [`CMD_W-1:0] cmd_sr_q;
  reg [`CMD_W-1:0] cmd_q;
  reg [`ROWS-1:0] addr_sr_q;
  reg [`ROW_W-1:0] data_sr_q;
  reg [`ID_W-1:0] id_sr_q;
  reg pend_q;
  reg [BUF_W-1:0] pend_word_q;
  reg [`CNT_W-1:0] wr_cnt_q;
  reg [BUF_W-1:0] wr_word_q;
  reg [`ROW_W-1:0] rd_word_d;
  reg rd_found_d;
  reg sdo_d;
  integer i;

  wire en_prog_w;
  wire sdi_w;
  wire mode_w;
  wire sclk_w;
  wire rise_w;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [BUF_W-1:0] buf_out_data;
  wire writer_ready_w;
  wire commit_w;
  wire [`ROWS*`ROW_W-1:0] rows_flat_w;
  wire [`ROW_W-1:0] lb_row_w;
  wire [`ROW_W-1:0] io_row_w;
  wire [`ROW_W-1:0] goe_row_w;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // RQ1: five link pins
  // Every pin is asynchronous; two stages before any use
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= `SYNC_IDLE; // Else enable looks low after reset
      sync2_q <= `SYNC_IDLE;
    end else begin
      sync1_q <= {goe_in, clock_input_two, serial_prog_out_i,
                  mode_in, serial_prog_in, prog_enable_n};
      sync2_q <= sync1_q;
    end
  end

  // RQ3: low enable enters
  assign en_prog_w = ~sync2_q[`SY_ENABLE_N];
  assign sdi_w = sync2_q[`SY_SDI];
  assign mode_w = sync2_q[`SY_MODE];
  assign sclk_w = sync2_q[`SY_SCLK];

  // Shift clock edge finder; clock is far slower than clk
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_w;
    end
  end

  // RQ9: shift on rising edge
  assign rise_w = sclk_w && !sclk_prev_q && en_prog_w;

  // ----------------------------------------------------------------
  // Programming state machine
  // ----------------------------------------------------------------
  // RQ2: serial-driven sequencer
  // Leaving programming mode aborts to idle; a queued write still ends
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cmd_sr_q <= `CMD_NOP;
      cmd_q <= `CMD_NOP;
      addr_sr_q <= `ADDR_ZERO;
      data_sr_q <= `ROW_ZERO;
      id_sr_q <= `ID_ZERO;
      pend_q <= 1'b0;
      pend_word_q <= {BUF_W{1'b0}};
    end else begin
      if (pend_q && buf_in_ready) begin
        pend_q <= 1'b0;
      end
      if (!en_prog_w) begin
        state_q <= ST_IDLE;
      end else if (rise_w) begin
        // RQ6: data in plus mode
        case (state_q)
          ST_IDLE: begin
            if (mode_w && sdi_w) begin
              state_q <= ST_SHIFT_CMD;
            end
          end
          ST_SHIFT_CMD: begin
            // RQ7: mode selects action
            if (!mode_w) begin
              cmd_sr_q <= {cmd_sr_q[`CMD_W-2:0], sdi_w};
            end else if (!sdi_w) begin
              cmd_q <= cmd_sr_q;
              state_q <= ST_EXEC;
              // RQ13: load identifier
              if (cmd_sr_q == `CMD_READ_ID) begin
                id_sr_q <= DEVICE_ID;
              end
            end else begin
              state_q <= ST_IDLE;
            end
          end
          ST_EXEC: begin
            if (!mode_w) begin
              // RQ5: shift data in
              case (cmd_q)
                `CMD_ADDR_SHIFT: begin
                  addr_sr_q <= {addr_sr_q[`ROWS-2:0], sdi_w};
                end
                `CMD_DATA_SHIFT, `CMD_VERIFY: begin
                  data_sr_q <= {data_sr_q[`ROW_W-2:0], sdi_w};
                end
                `CMD_READ_ID: begin
                  id_sr_q <= {id_sr_q[`ID_W-2:0], sdi_w};
                end
                default: begin
                  cmd_sr_q <= cmd_sr_q;
                end
              endcase
            end else begin
              state_q <= ST_SHIFT_CMD;
              case (cmd_q)
                `CMD_PROGRAM, `CMD_ERASE: begin
                  // Queued; cannot stall the programmer directly
                  pend_q <= 1'b1;
                  pend_word_q <= {cmd_q == `CMD_ERASE, addr_sr_q,
                                  data_sr_q};
                end
                `CMD_VERIFY: begin
                  data_sr_q <= rd_word_d;
                end
                default: begin
                  cmd_sr_q <= cmd_sr_q;
                end
              endcase
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Write buffer and cell writer
  // ----------------------------------------------------------------
  // Full buffer holds the request pending, seen as busy on data out
  two_entry_buf #(
    .WIDTH(BUF_W)
  ) u_wbuf (
    .clk(clk),
    .rst(rst),
    .in_valid(pend_q),
    .in_ready(buf_in_ready),
    .in_data(pend_word_q),
    .out_valid(buf_out_valid),
    .out_ready(writer_ready_w),
    .out_data(buf_out_data)
  );

  assign writer_ready_w = (wr_cnt_q == `CNT_ZERO);
  assign commit_w = (wr_cnt_q == `CNT_ONE);

  // Each write holds the cells for the full pulse time
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_cnt_q <= `CNT_ZERO;
      wr_word_q <= {BUF_W{1'b0}};
    end else if (buf_out_valid && writer_ready_w) begin
      wr_cnt_q <= PULSE_CYC[`CNT_W-1:0];
      wr_word_q <= buf_out_data;
    end else if (!writer_ready_w) begin
      wr_cnt_q <= wr_cnt_q - `CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Non-volatile rows
  // ----------------------------------------------------------------
  genvar r;
  generate
    for (r = 0; r < `ROWS; r = r + 1) begin : g_row
      reg [`ROW_W-1:0] cell_q;
      // RQ14: cells never reset
      // RQ12: address bit enables row
      always @(posedge clk) begin
        if (commit_w && wr_word_q[`ROW_W + r]) begin
          cell_q <= wr_word_q[BUF_W-1] ? `ROW_ZERO
                                       : wr_word_q[`ROW_W-1:0];
        end
      end
      assign rows_flat_w[r*`ROW_W +: `ROW_W] = cell_q;
    end
  endgenerate

  // RQ12: verify reads lowest enabled row
  always @* begin
    rd_word_d = `ROW_ZERO;
    rd_found_d = 1'b0;
    for (i = 0; i < `ROWS; i = i + 1) begin
      if (addr_sr_q[i] && !rd_found_d) begin
        rd_word_d = rows_flat_w[i*`ROW_W +: `ROW_W];
        rd_found_d = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial data out
  // ----------------------------------------------------------------
  // RQ8: shift register on data out
  always @* begin
    sdo_d = 1'b0;
    if (state_q == ST_EXEC) begin
      case (cmd_q)
        `CMD_ADDR_SHIFT: sdo_d = addr_sr_q[`ROWS-1];
        `CMD_DATA_SHIFT, `CMD_VERIFY: sdo_d = data_sr_q[`ROW_W-1];
        `CMD_READ_ID: sdo_d = id_sr_q[`ID_W-1];
        default: sdo_d = 1'b0;
      endcase
    end else if (state_q == ST_SHIFT_CMD) begin
      // Ready flag lets the programmer poll for write completion
      sdo_d = !pend_q && !buf_out_valid && writer_ready_w;
    end
  end

  // ----------------------------------------------------------------
  // Pin roles and clock routing
  // ----------------------------------------------------------------
  assign lb_row_w = rows_flat_w[`ROW_LB_ROUTE*`ROW_W +: `ROW_W];
  assign io_row_w = rows_flat_w[`ROW_IO_ROUTE*`ROW_W +: `ROW_W];
  assign goe_row_w = rows_flat_w[`ROW_GOE_CFG*`ROW_W +: `ROW_W];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_prog_out_o <= 1'b0;
      serial_prog_out_oe <= 1'b0;
      array_in_q <= 3'h0;
      clock_net_q <= 1'b0;
      lb_clock_q <= {`LB_COUNT{1'b0}};
      io_clock_q <= {`IO_COUNT{1'b0}};
      global_oe_q <= 1'b0;
      goe_array_in_q <= 1'b0;
      prog_mode_q <= 1'b0;
    end else begin
      prog_mode_q <= en_prog_w;
      // RQ3: drive data out in mode
      serial_prog_out_oe <= en_prog_w;
      serial_prog_out_o <= en_prog_w & sdo_d;
      // RQ4: plain inputs when enable high
      array_in_q <= en_prog_w ? 3'h0
                    : {mode_w, sync2_q[`SY_SDO_PIN], sdi_w};
      // RQ10: clock network when enable high
      clock_net_q <= !en_prog_w && sclk_w;
      // RQ11: per-target clock option
      lb_clock_q <= (!en_prog_w && sclk_w) ?
                    lb_row_w[`LB_COUNT-1:0] : {`LB_COUNT{1'b0}};
      io_clock_q <= (!en_prog_w && sclk_w) ?
                    io_row_w[`IO_COUNT-1:0] : {`IO_COUNT{1'b0}};
      // RQ15: global pin role
      if (goe_row_w[`GOE_MODE_BIT]) begin
        global_oe_q <= sync2_q[`SY_GOE];
        goe_array_in_q <= 1'b0;
      end else begin
        global_oe_q <= 1'b1;
        goe_array_in_q <= sync2_q[`SY_GOE];
      end
    end
  end

endmodule

`default_nettype wire

// ---- test/serial_cfg_port_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module serial_cfg_port_checker (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic prog_enable_n, // Enable pin
  input wire logic serial_prog_in, // Data in pin
  input wire logic mode_in, // Mode pin
  input wire logic serial_prog_out_i, // Data out wire
  input wire logic serial_prog_out_o, // Data out value
  input wire logic serial_prog_out_oe, // Data out enable
  input wire logic clock_input_two, // Shift clock pin
  input wire logic goe_in, // Global pin
  input wire logic [2:0] array_in_q, // Array inputs
  input wire logic clock_net_q, // Clock network
  input wire logic [15:0] lb_clock_q, // Block clocks
  input wire logic [31:0] io_clock_q, // Cell clocks
  input wire logic global_oe_q, // Global enable
  input wire logic goe_array_in_q, // Global as input
  input wire logic prog_mode_q // Programming mode
);
  // ----------------------------------------------------------------
  // Helpers and sequences
  // ----------------------------------------------------------------
  // Cycles since reset, so $past never looks back into reset
  logic [2:0] up_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h7) begin
      up_q <= up_q + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence held_high;
    ((up_q == 3'h7) && prog_enable_n) [*5];
  endsequence
  sequence went_low;
    $fell(prog_enable_n) ##1 !prog_enable_n [*3];
  endsequence
  sequence prog_steady;
    prog_mode_q ##1 prog_mode_q;
  endsequence
  prog_oe_a:
    assert property (serial_prog_out_oe == prog_mode_q)
    else $error("data out enable differs from mode");
  enter_mode_a:
    assert property (went_low |-> prog_mode_q)
    else $error("enable low did not enter programming");
  leave_mode_a:
    assert property ($rose(prog_enable_n) |-> ##[1:4] !prog_mode_q)
    else $error("enable high did not leave programming");
  array_follow_a:
    assert property (held_high |-> array_in_q == {$past(mode_in, 3),
      $past(serial_prog_out_i, 3), $past(serial_prog_in, 3)})
    else $error("array inputs do not follow pins");
  clock_follow_a:
    assert property (held_high |-> clock_net_q == $past(clock_input_two, 3))
    else $error("clock network does not follow pin");
  prog_quiet_a:
    assert property (prog_steady |-> array_in_q == 3'h0 && !clock_net_q)
    else $error("array side active while programming");
  route_off_a:
    assert property (!clock_net_q && !$past(clock_net_q) |->
      lb_clock_q == 16'h0000 && io_clock_q == 32'h0000_0000)
    else $error("routed clock high without clock");
  goe_high_a:
    assert property (((up_q == 3'h7) && goe_in) [*4] |-> global_oe_q)
    else $error("global enable low with pin high");
  goe_both_a:
    assert property (goe_array_in_q |-> global_oe_q)
    else $error("global pin input while outputs disabled");
endmodule
`default_nettype wire

// ---- test/prog_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module prog_host_model (
  input wire logic clk, // Clock
  input wire logic serial_prog_out_i, // Data out wire
  output logic prog_enable_n, // Enable pin
  output logic serial_prog_in, // Data in pin
  output logic mode_in, // Mode pin
  output logic clock_input_two // Shift clock pin
);
  // ----------------------------------------------------------------
  // Programmer side of the five-pin link
  // ----------------------------------------------------------------
  // Pins idle, enable released
  initial begin
    prog_enable_n = 1'b1;
    serial_prog_in = 1'b0;
    mode_in = 1'b0;
    clock_input_two = 1'b0;
  end
  // Whole pin levels; enable held across sequences
  task pins(input logic en_n, input logic d, input logic m, input logic c);
    @(posedge clk);
    prog_enable_n <= en_n;
    serial_prog_in <= d;
    mode_in <= m;
    clock_input_two <= c;
  endtask
  // Steer both pins, then one 40 ns clock; s is the prior answer
  task step(input logic m, input logic d, input logic p, output logic s);
    @(posedge clk);
    mode_in <= m;
    serial_prog_in <= d;
    repeat (2) @(posedge clk);
    @(negedge clk);
    s = serial_prog_out_i;
    @(posedge clk);
    clock_input_two <= p;
    repeat (4) @(posedge clk);
    clock_input_two <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cfg_port_regs.vh"
module testbench;
  localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary identifier value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic goe_in = 1'b0;
  logic pin_drive = 1'b0;
  wire prog_enable_n, serial_prog_in, mode_in, clock_input_two;
  wire serial_prog_out_o, serial_prog_out_oe, serial_prog_out_i;
  wire clock_net_q, global_oe_q, goe_array_in_q, prog_mode_q;
  wire [2:0] array_in_q;
  wire [15:0] lb_clock_q;
  wire [31:0] io_clock_q;
  int error_cnt = 0;
  int checked = 0;
  logic [31:0] got;
  logic s;
  logic [9:0] r;
  // Rows: sdi mode pin sclk goe | array_in(3) clock_net global_oe
  logic [9:0] rows [5] = '{10'h204, 10'h173, 10'h0a9, 10'h3de, 10'h063};
  // ----------------------------------------------------------------
  // Clock, pin wire and instances
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  // Device drives data out while programming, else the bench does
  assign serial_prog_out_i = serial_prog_out_oe ? serial_prog_out_o : pin_drive;
  serial_cfg_port #(.DEVICE_ID(ID_VAL)) i_serial_cfg_port (.*);
  prog_host_model i_prog_host_model (.*);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Outputs lag pins by three edges; look off the edge
  task settle();
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask
  task fin();
    i_prog_host_model.step(1'b1, 1'b0, 1'b1, s);
  endtask
  task send_cmd(input logic [2:0] c);
    for (int i = 2; i >= 0; i--) begin
      i_prog_host_model.step(1'b0, c[i], 1'b1, s);
    end
    fin();
  endtask
  // MSB first both ways; each answer is the bit before the shift
  task shift(input int n, input logic [31:0] v);
    got = 32'h0000_0000;
    for (int i = n - 1; i >= 0; i--) begin
      i_prog_host_model.step(1'b0, v[i], 1'b1, s);
      got = {got[30:0], s};
    end
  endtask
  // Poll ready without clocking; bounded so a stuck writer is seen
  task wait_ready();
    int k;
    i_prog_host_model.step(1'b0, 1'b0, 1'b0, s);
    check(32'(s), 32'h0000_0000);
    k = 0;
    while (s !== 1'b1 && k < 12) begin
      i_prog_host_model.step(1'b0, 1'b0, 1'b0, s);
      k++;
    end
    check(32'(s), 32'h0000_0001);
  endtask
  task op(input logic [15:0] a, input logic [31:0] d, input logic [2:0] c);
    send_cmd(`CMD_ADDR_SHIFT);
    shift(16, {16'h0000, a});
    fin();
    if (c == `CMD_PROGRAM) begin
      send_cmd(`CMD_DATA_SHIFT);
      shift(32, d);
      fin();
    end
    send_cmd(c);
    fin();
    if (c != `CMD_VERIFY) begin
      wait_ready();
    end
  endtask
  task rd(input logic [15:0] a, input logic [31:0] exp);
    op(a, 32'h0000_0000, `CMD_VERIFY);
    send_cmd(`CMD_DATA_SHIFT);
    shift(32, 32'h0000_0000);
    fin();
    check(got, exp);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (9) @(posedge clk);
    @(negedge clk);
    check(32'({array_in_q, clock_net_q, prog_mode_q}), 32'h0000_0000);
    @(posedge clk);
    rst <= 1'b0;
    i_prog_host_model.pins(1'b0, 1'b0, 1'b0, 1'b0);
    settle();
    check(32'({prog_mode_q, serial_prog_out_oe, array_in_q}), 32'h18);
    i_prog_host_model.step(1'b1, 1'b1, 1'b1, s);
    op(16'h0007, 32'h0000_0000, `CMD_ERASE);
    rd(16'h0002, 32'h0000_0000);
    op(16'h0001, 32'h0000_c3a5, `CMD_PROGRAM);
    op(16'h0006, 32'h5a5a_0f0f, `CMD_PROGRAM);
    rd(16'h0004, 32'h5a5a_0f0f);
    rd(16'h0001, 32'h0000_c3a5);
    rd(16'h0000, 32'h0000_0000);
    send_cmd(`CMD_READ_ID);
    shift(8, 32'h0000_0000);
    check(got, 32'(ID_VAL));
    fin();
    i_prog_host_model.step(1'b1, 1'b1, 1'b1, s);
    i_prog_host_model.pins(1'b1, 1'b0, 1'b0, 1'b0);
    // Reset again: the stored pattern must survive it
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    check(32'({prog_mode_q, serial_prog_out_oe}), 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      i_prog_host_model.pins(1'b1, r[9], r[8], r[6]);
      pin_drive <= r[7];
      goe_in <= r[5];
      settle();
      check(32'(array_in_q), 32'(r[4:2]));
      check(32'(clock_net_q), 32'(r[1]));
      check(32'(lb_clock_q), 32'({16{r[6]}} & 16'hc3a5));
      check(io_clock_q, {32{r[6]}} & 32'h5a5a_0f0f);
      check(32'({global_oe_q, goe_array_in_q}), 32'({r[0], 1'b0}));
    end
    i_prog_host_model.pins(1'b0, 1'b0, 1'b0, 1'b0);
    settle();
    i_prog_host_model.step(1'b1, 1'b1, 1'b1, s);
    op(16'h0004, 32'h0000_0000, `CMD_PROGRAM);
    i_prog_host_model.step(1'b1, 1'b1, 1'b1, s);
    i_prog_host_model.pins(1'b1, 1'b0, 1'b0, 1'b0);
    goe_in <= 1'b1;
    settle();
    check(32'({global_oe_q, goe_array_in_q}), 32'h0000_0003);
    goe_in <= 1'b0;
    settle();
    check(32'({global_oe_q, goe_array_in_q}), 32'h0000_0002);
    end_of_test();
  end
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule
bind serial_cfg_port serial_cfg_port_checker i_serial_cfg_port_checker (.*);
`default_nettype wire
